/* File: hw/serial_switch_pkg.sv */
package serial_switch_pkg;
  // Link timing
  localparam int CLK_HZ         = 125_000_000;
  localparam int BAUD_RATE      = 19200;
  localparam int BIT_CYCLES_DEF = CLK_HZ / BAUD_RATE;
  localparam int DATA_BITS      = 8;
  localparam int STOP_BITS      = 1;
  localparam int CNT_W          = 16;

  // Command codes
  localparam logic [7:0] CMD_CH_FIRST  = 8'h10;
  localparam logic [7:0] CMD_CH_LAST   = 8'h1f;
  localparam logic [7:0] CMD_VIDEO_OFF = 8'h71;
  localparam logic [7:0] CMD_CH_OFFSET = 8'h0f;

  // Topology limits
  localparam int         NUM_CHANNELS   = 16;
  localparam logic [4:0] MAX_CHANNEL    = 5'h10;
  localparam int         BOX_PORTS      = 8;
  localparam logic [1:0] MAX_LEVELS     = 2'h2;
  localparam logic [4:0] DECIMAL_TEN    = 5'h0a;

  // Values after reset
  localparam logic [4:0]  CHANNEL_RESET = 5'h00;
  localparam logic [15:0] SEEN_RESET    = 16'h0000;

  typedef struct packed {
    logic       valid;
    logic [4:0] channel;
  } sel_req_type;

  typedef struct packed {
    logic [3:0] d0;
    logic [3:0] d1;
    logic [3:0] d2;
    logic [3:0] d3;
    logic [2:0] digits;
  } cas_addr_type;
endpackage : serial_switch_pkg

/* File: hw/serial_port_switch_command.sv */
`timescale 1ns/1ps
module serial_port_switch_command #(
  parameter int BIT_CYCLES = serial_switch_pkg::BIT_CYCLES_DEF
) (
  input  wire logic                            clk,
  input  wire logic                            rstn,
  input  wire logic                            ce,
  input  wire logic                            syncMode,
  input  wire logic                            rxd,
  output logic                                 txd,
  input  wire serial_switch_pkg::sel_req_type  localReq,
  output logic [4:0]                           channel,
  output logic                                 videoOn,
  input  wire logic [1:0]                      casLevel,
  input  wire logic [4:0]                      casPort1,
  input  wire logic [4:0]                      casPort2,
  output serial_switch_pkg::cas_addr_type      casAddr,
  output logic                                 casError,
  input  wire logic [1:0]                      boxAddr,
  input  wire logic [2:0]                      boxPort,
  output logic [4:0]                           powerPort,
  input  wire logic [15:0]                     portAttached,
  output logic                                 offerAdd,
  output logic [3:0]                           offerPort
);
  import serial_switch_pkg::*;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_type;

  localparam logic [CNT_W-1:0] BIT_LAST  = CNT_W'(BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(BIT_CYCLES / 2 - 1);
  localparam logic [2:0]       BIT_TOP   = 3'(DATA_BITS - 1);

  // Decode a command byte into a channel; valid only for known codes
  function automatic sel_req_type decode_cmd(input logic [7:0] code);
    sel_req_type r;
    r.valid   = 1'b0;
    r.channel = CHANNEL_RESET;
    if (code >= CMD_CH_FIRST && code <= CMD_CH_LAST) begin
      r.valid   = 1'b1;
      r.channel = 5'(code - CMD_CH_OFFSET);
    end else if (code == CMD_VIDEO_OFF) begin
      r.valid   = 1'b1;
      r.channel = CHANNEL_RESET;
    end
    return r;
  endfunction : decode_cmd

  // Encode a channel as its command byte
  function automatic logic [7:0] encode_cmd(input logic [4:0] ch);
    return (ch == CHANNEL_RESET) ? CMD_VIDEO_OFF : 8'(ch) + CMD_CH_OFFSET;
  endfunction : encode_cmd

  // Port number 1..16 as two decimal digits {tens, units}
  function automatic logic [7:0] to_digits(input logic [4:0] p);
    logic [4:0] u;
    u = (p >= DECIMAL_TEN) ? 5'(p - DECIMAL_TEN) : p;
    return {4'((p >= DECIMAL_TEN) ? 1 : 0), u[3:0]};
  endfunction : to_digits

  rx_state_type     rxState;
  tx_state_type     txState;
  logic [CNT_W-1:0] rxCnt;
  logic [CNT_W-1:0] txCnt;
  logic [2:0]       rxBit;
  logic [2:0]       txBit;
  logic [7:0]       rxShift;
  logic [7:0]       rxByte;
  logic             rxDone;
  logic [7:0]       txShift;
  logic             pendValid;
  logic [7:0]       pendCode;
  logic [15:0]      seen;
  sel_req_type      rxCmd;
  logic             acceptRx;
  logic             acceptLocal;
  logic             txLoad;
  logic             newFound;
  logic [3:0]       newIdx;

  assign rxCmd       = decode_cmd(rxByte);
  assign acceptRx    = rxDone && syncMode && rxCmd.valid;
  assign acceptLocal = localReq.valid && localReq.channel <= MAX_CHANNEL
                       && localReq.channel != channel;
  assign txLoad      = txState == TX_IDLE && pendValid;
  assign videoOn     = channel != CHANNEL_RESET;

  // Receiver: sample mid-bit, good stop bit required to deliver a byte
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxState <= RX_IDLE;
      rxCnt   <= '0;
      rxBit   <= '0;
      rxShift <= '0;
      rxByte  <= '0;
      rxDone  <= 1'b0;
    end else if (ce) begin
      rxDone <= 1'b0;
      case (rxState)
        RX_IDLE: begin
          rxCnt <= '0;
          if (!rxd && syncMode) begin
            rxState <= RX_START;
          end
        end
        RX_START: begin
          if (rxCnt == HALF_LAST) begin
            rxCnt   <= '0;
            rxBit   <= '0;
            rxState <= rxd ? RX_IDLE : RX_DATA;                          // Glitch rejected
          end else begin
            rxCnt <= rxCnt + 1'b1;
          end
        end
        RX_DATA: begin
          if (rxCnt == BIT_LAST) begin
            rxCnt   <= '0;
            rxShift <= {rxd, rxShift[7:1]};                              // LSB first
            rxBit   <= rxBit + 1'b1;
            if (rxBit == BIT_TOP) begin
              rxState <= RX_STOP;
            end
          end else begin
            rxCnt <= rxCnt + 1'b1;
          end
        end
        RX_STOP: begin
          if (rxCnt == BIT_LAST) begin
            rxState <= RX_IDLE;
            rxByte  <= rxShift;
            rxDone  <= rxd;                                              // Framing error drops byte
          end else begin
            rxCnt <= rxCnt + 1'b1;
          end
        end
        default: rxState <= RX_IDLE;
      endcase
    end
  end

  // Channel selection; a received command wins over a local request
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      channel <= CHANNEL_RESET;
    end else if (ce) begin
      if (acceptRx) begin
        channel <= rxCmd.channel;
      end else if (acceptLocal) begin
        channel <= localReq.channel;
      end
    end
  end

  // One pending byte; a newer one replaces an unsent one since only the latest matters
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pendValid <= 1'b0;
      pendCode  <= '0;
    end else if (ce) begin
      if (acceptRx) begin
        pendValid <= 1'b1;
        pendCode  <= rxByte;
      end else if (acceptLocal && syncMode) begin
        pendValid <= 1'b1;
        pendCode  <= encode_cmd(localReq.channel);
      end else if (txLoad) begin
        pendValid <= 1'b0;
      end
    end
  end

  // Transmitter: no handshake lines, line idles high
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txState <= TX_IDLE;
      txCnt   <= '0;
      txBit   <= '0;
      txShift <= '0;
      txd     <= 1'b1;
    end else if (ce) begin
      case (txState)
        TX_IDLE: begin
          txCnt <= '0;
          txd   <= 1'b1;
          if (pendValid) begin
            txShift <= pendCode;
            txd     <= 1'b0;
            txState <= TX_START;
          end
        end
        TX_START, TX_DATA: begin
          if (txCnt == BIT_LAST) begin
            txCnt <= '0;
            if (txState == TX_START) begin
              txBit   <= '0;
              txd     <= txShift[0];
              txState <= TX_DATA;
            end else if (txBit == BIT_TOP) begin
              txd     <= 1'b1;                                           // No parity bit
              txState <= TX_STOP;
            end else begin
              txBit   <= txBit + 1'b1;
              txd     <= txShift[txBit + 3'h1];
            end
          end else begin
            txCnt <= txCnt + 1'b1;
          end
        end
        TX_STOP: begin
          if (txCnt == CNT_W'(BIT_CYCLES * STOP_BITS - 1)) begin
            txState <= TX_IDLE;
          end else begin
            txCnt <= txCnt + 1'b1;
          end
        end
        default: txState <= TX_IDLE;
      endcase
    end
  end

  // Cascade address and power port id
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      casAddr   <= '0;
      casError  <= 1'b0;
      powerPort <= '0;
    end else if (ce) begin
      powerPort <= {boxAddr, boxPort};
      casError  <= casLevel > MAX_LEVELS || casLevel == 2'h0;
      casAddr   <= '0;
      if (casLevel == 2'h1) begin
        {casAddr.d0, casAddr.d1} <= to_digits(casPort1);
        casAddr.digits           <= 3'h2;
      end else if (casLevel == MAX_LEVELS) begin
        {casAddr.d0, casAddr.d1} <= to_digits(casPort1);
        {casAddr.d2, casAddr.d3} <= to_digits(casPort2);
        casAddr.digits           <= 3'h4;
      end
    end
  end

  // Lowest port with a lower unit attached for the first time
  always_comb begin
    newFound = 1'b0;
    newIdx   = '0;
    for (int i = NUM_CHANNELS - 1; i >= 0; i--) begin
      if (portAttached[i] && !seen[i]) begin
        newFound = 1'b1;
        newIdx   = 4'(i);
      end
    end
  end

  // Each port offers once; later reattaches stay quiet
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seen      <= SEEN_RESET;
      offerAdd  <= 1'b0;
      offerPort <= '0;
    end else if (ce) begin
      offerAdd <= newFound;
      if (newFound) begin
        seen[newIdx] <= 1'b1;
        offerPort    <= newIdx;
      end
    end
  end

  sequence s_tx_launch;
    ce && txState == TX_IDLE && pendValid;
  endsequence

  sequence s_rx_accept;
    ce && acceptRx;
  endsequence

  a_rx_channel_set: assert property (@(posedge clk) disable iff (!rstn)
    s_rx_accept |=> channel == $past(rxCmd.channel))
    else $error("received command did not set channel");

  a_rx_code_map: assert property (@(posedge clk) disable iff (!rstn)
    s_rx_accept and (rxByte >= 8'h10 && rxByte <= 8'h1f)
      |=> channel == 5'($past(rxByte) - 8'h0f))
    else $error("channel code maps to wrong channel");

  a_video_off_cmd: assert property (@(posedge clk) disable iff (!rstn)
    s_rx_accept and rxByte == 8'h71 |=> !videoOn && channel == 5'h00)
    else $error("video off command not obeyed");

  a_echo_queued: assert property (@(posedge clk) disable iff (!rstn)
    s_rx_accept |=> pendValid && pendCode == $past(rxByte))
    else $error("valid command not queued for echo");

  a_bad_ignored: assert property (@(posedge clk) disable iff (!rstn)
    ce && rxDone && !rxCmd.valid && !localReq.valid |=> $stable(channel) && $stable(pendCode))
    else $error("unknown byte had an effect");

  a_local_sends: assert property (@(posedge clk) disable iff (!rstn)
    ce && !acceptRx && acceptLocal && syncMode
      |=> pendValid && pendCode == encode_cmd($past(localReq.channel)))
    else $error("channel change not announced");

  a_tx_start_bit: assert property (@(posedge clk) disable iff (!rstn)
    s_tx_launch |=> !txd ##1 (!txd || !ce))
    else $error("start bit not driven");

  a_sync_off_quiet: assert property (@(posedge clk) disable iff (!rstn)
    !syncMode && txState == TX_IDLE && !pendValid |=> txd && !pendValid)
    else $error("transmit outside lockstep mode");

  a_cascade_limit: assert property (@(posedge clk) disable iff (!rstn)
    ce && casLevel == 2'h3 |=> casError && casAddr.digits == 3'h0)
    else $error("third cascade level accepted");

  a_power_port: assert property (@(posedge clk) disable iff (!rstn)
    ce |=> powerPort[2:0] == $past(boxPort) && powerPort[4:3] == $past(boxAddr))
    else $error("power port id wrong");

  a_offer_once: assert property (@(posedge clk) disable iff (!rstn)
    ce && offerAdd ##1 ce |-> !(offerAdd && offerPort == $past(offerPort)))
    else $error("offer repeated for one port");
endmodule : serial_port_switch_command

/* File: testbench/remote_ctrl_model.sv */
`timescale 1ns/1ps
// Far-end controller: drives the serial input and decodes the serial output
module remote_ctrl_model #(
  parameter int BIT_CYCLES = 16
) (
  input  wire logic       clk,
  input  wire logic       lineIn,
  output logic            lineOut,
  output logic            gotByte,
  output logic            stopOk,
  output logic [7:0]      rxByte
);
  logic [7:0] data;

  // Idle line is mark; nothing is sent outside frames
  initial begin
    lineOut = 1'b1;
    gotByte = 1'b0;
    stopOk  = 1'b0;
    rxByte  = 8'h00;
  end

  // Start, eight data bits LSB first, no parity, one stop bit
  task automatic send(input logic [7:0] b, input logic stopBit);
    logic [9:0] frame;
    frame = {stopBit, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      lineOut = frame[i];
      repeat (BIT_CYCLES - 1) @(negedge clk);
    end
    @(negedge clk);
    lineOut = 1'b1;
  endtask : send

  // Samples bit middles; no handshake lines exist, so nothing can stall
  always begin
    @(negedge lineIn);
    repeat (BIT_CYCLES / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge clk);
      data[i] = lineIn;
    end
    repeat (BIT_CYCLES) @(posedge clk);
    stopOk  <= lineIn;
    rxByte  <= data;
    gotByte <= 1'b1;
    @(posedge clk);
    gotByte <= 1'b0;
  end
endmodule : remote_ctrl_model

/* File: testbench/tb.sv */
`timescale 1ns/1ps
module tb;
  import serial_switch_pkg::*;
  localparam int BIT = 16;
  logic         clk, rstn, ce, syncMode, rxd, txd, videoOn, casError;
  logic         offerAdd, gotByte, stopOk;
  logic [4:0]   channel, casPort1, casPort2, powerPort, ch;
  logic [1:0]   casLevel, boxAddr;
  logic [2:0]   boxPort;
  logic [15:0]  portAttached;
  logic [3:0]   offerPort;
  logic [7:0]   rxByte, code;
  sel_req_type  localReq;
  cas_addr_type casAddr;
  logic [7:0]   byteQ[$];
  logic [3:0]   offerQ[$];
  int           errorCnt, nChecks;
  integer       seed;
  logic         err;

  serial_port_switch_command #(.BIT_CYCLES(BIT)) i_dut (
    .clk(clk), .rstn(rstn), .ce(ce), .syncMode(syncMode), .rxd(rxd), .txd(txd),
    .localReq(localReq), .channel(channel), .videoOn(videoOn), .casLevel(casLevel),
    .casPort1(casPort1), .casPort2(casPort2), .casAddr(casAddr), .casError(casError),
    .boxAddr(boxAddr), .boxPort(boxPort), .powerPort(powerPort),
    .portAttached(portAttached), .offerAdd(offerAdd), .offerPort(offerPort));

  remote_ctrl_model #(.BIT_CYCLES(BIT)) i_model (
    .clk(clk), .lineIn(txd), .lineOut(rxd), .gotByte(gotByte), .stopOk(stopOk),
    .rxByte(rxByte));

  // Free-running clock
  always #4 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    nChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("unexpected at %0t: %s got %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check

  task automatic finishTest();
    if (errorCnt == 0 && nChecks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finishTest

  // Bounded wait for expected events, then a quiet gap so strays surface
  task automatic waitDrain();
    int n;
    n = 0;
    while ((byteQ.size() != 0 || offerQ.size() != 0) && n < 40 * BIT) begin
      @(negedge clk);
      n++;
    end
    if (n >= 40 * BIT) begin
      check(1, 0, "wait bound");
      finishTest();
    end
    repeat (12 * BIT) @(negedge clk);
  endtask : waitDrain

  task automatic localSel(input logic [4:0] c);
    localReq = {1'b1, c};
    @(negedge clk);
    localReq = '0;
    @(negedge clk);
  endtask : localSel

  // Result watcher: every byte or offer must match the oldest note
  always @(posedge clk) begin
    if (gotByte) begin
      check(stopOk, 1, "stop bit");
      if (byteQ.size() == 0)
        check(1, 0, "stray byte");
      else
        check(rxByte, byteQ.pop_front(), "tx byte");
    end
    if (offerAdd) begin
      if (offerQ.size() == 0)
        check(1, 0, "stray offer");
      else
        check(offerPort, offerQ.pop_front(), "offer port");
    end
  end

  // Run limit
  initial begin
    repeat (60000) @(posedge clk);
    check(1, 0, "timeout");
    finishTest();
  end

  initial begin
    clk = 1'b0;
    seed = 94;
    errorCnt = 0;
    nChecks = 0;
    {ce, syncMode} = 2'b11;
    localReq = '0;
    {casLevel, casPort1, casPort2, boxAddr, boxPort} = '0;
    portAttached = '0;
    rstn = 1'b0;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    check({txd, channel, videoOn}, 7'h40, "reset state");
    // Video-off code first, then 10..1F back to back
    for (int i = 0; i < 17; i++) begin
      code = (i == 0) ? CMD_VIDEO_OFF : 8'(CMD_CH_FIRST + i - 1);
      byteQ.push_back(code);
      i_model.send(code, 1'b1);
      repeat (4) @(negedge clk);
      check(channel, i, "channel");
      check(videoOn, i != 0, "video");
    end
    waitDrain();
    // Unknown codes: no change, no echo
    for (int i = 0; i < 20; i++) begin
      do code = 8'($random(seed)); while (code inside {[8'h10:8'h1f], 8'h71});
      i_model.send(code, 1'b1);
      repeat (4) @(negedge clk);
      check(channel, 16, "unknown code");
    end
    i_model.send(8'h12, 1'b0);
    repeat (4) @(negedge clk);
    check(channel, 16, "framing");
    syncMode = 1'b0;
    i_model.send(8'h13, 1'b1);
    localSel(5'h05);
    check(channel, 5, "local no sync");
    // Clock enable low must freeze the channel even for a legal request
    ce = 1'b0;
    localSel(5'h03);
    check(channel, 5, "ce freeze");
    ce = 1'b1;
    waitDrain();
    syncMode = 1'b1;
    // Local changes announce; repeats and out-of-range do not
    byteQ.push_back(CMD_VIDEO_OFF);
    localSel(5'h00);
    check(channel, 0, "local 0");
    waitDrain();
    localSel(5'h00);
    localSel(5'h11);
    check(channel, 0, "local refused");
    byteQ.push_back(8'h18);
    localSel(5'h09);
    check({channel, videoOn}, {5'h09, 1'b1}, "local 9");
    waitDrain();
    // Cascade address and power port, every level code
    for (int i = 0; i < 12; i++) begin
      casLevel = 2'(i);
      casPort1 = 5'(1 + {$random(seed)} % 16);
      casPort2 = 5'(1 + {$random(seed)} % 16);
      {boxAddr, boxPort} = 5'($random(seed));
      repeat (2) @(negedge clk);
      err = (casLevel == 2'h0 || casLevel == 2'h3);
      check(casError, err, "cascade error");
      check(casAddr.digits, err ? 0 : 2 * casLevel, "digits");
      check(powerPort, {boxAddr, boxPort}, "power port");
      if (!err)
        check({casAddr.d0, casAddr.d1}, {4'(casPort1 / 10), 4'(casPort1 % 10)}, "lvl1");
      if (casLevel == 2'h2)
        check({casAddr.d2, casAddr.d3}, {4'(casPort2 / 10), 4'(casPort2 % 10)}, "lvl2");
    end
    // Two first attaches offer in order; a re-attach stays silent
    offerQ.push_back(4'h3);
    offerQ.push_back(4'h7);
    portAttached = 16'h0088;
    repeat (6) @(negedge clk);
    portAttached = 16'h0000;
    repeat (4) @(negedge clk);
    portAttached = 16'h0008;
    waitDrain();
    finishTest();
  end
endmodule : tb
